/* ascc_bus.sv */
// Simple word write/read master toward the device register port
`timescale 1ns/1ps
`default_nettype none
module ascc_bus
  import ascc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Request from the sequencer
  input wire logic req,
  input wire logic req_wr,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic req_done,
  output logic [15:0] req_rdata,
  // Device register port
  output logic dev_sel,
  output logic dev_wr,
  output logic [15:0] dev_addr,
  output logic [15:0] dev_wdata,
  input wire logic [15:0] dev_rdata,
  input wire logic dev_ack
);
  logic busy_q;
  logic [15:0] rdata_q;
  logic [15:0] addr_q;
  logic [15:0] wdata_q;
  logic wr_q;
  logic done_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic [15:0] rd_s1_q;
  logic [15:0] rd_s2_q;
  // Acknowledge and data come from the device pins: two stages first
  always_ff @(posedge clk_sys) begin
    ack_s1_q <= nrst ? dev_ack : 1'b0;
    ack_s2_q <= nrst ? ack_s1_q : 1'b0;
    rd_s1_q <= dev_rdata;
    rd_s2_q <= rd_s1_q;
  end
  // One access at a time; held until the device acknowledges
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
      wr_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      done_q <= 1'b0;
      // No new access until the old acknowledge has left the synchroniser,
      // nor in the cycle of a completion, while the sequencer still shows
      // the finished request
      if (!busy_q && req && !done_q && !ack_s2_q) begin
        busy_q <= 1'b1;
        addr_q <= req_addr;
        wdata_q <= req_wdata;
        wr_q <= req_wr;
      end else if (busy_q && ack_s2_q) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
        rdata_q <= rd_s2_q;
      end
    end
  end
  assign dev_sel = busy_q;
  assign dev_wr = wr_q;
  assign dev_addr = addr_q;
  assign dev_wdata = wdata_q;
  assign req_done = done_q;
  assign req_rdata = rdata_q;
endmodule : ascc_bus
`default_nettype wire

/* ascc_ctrl.sv */
// Host-side sequencer that configures the three clock domains of the codec
// Notes on behaviour
// - Main sample rates share main clock family
// - Main rate code 000..100, family bit matches
// - Loop source only once loop enabled
// - Always-on loop needs running and rate set
// - Source ready before enable; disable before removal
// - Running main change: one combined write
// - Rate-only change clears enable first
// - Mute analogue paths before source change
// - Second rate code 000..100, matches source
// - Second sample rates share second family
// - Keep second clock off when unused
// - Second source ready before enable
// - Second change one write; status readback
// - Core word is MHz times 64
// - Always-on loop core option, loop ready
// - Core word first, source write applies
// - Core source ready; disable to reconfigure
// - Clocks configured before any audio path; the code gates audio on the main clock only
`timescale 1ns/1ps
`default_nettype none
module ascc_ctrl
  import ascc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // User command: configure one domain
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire ascc_pkg::ascc_dom_e cmd_domain,
  input wire logic cmd_enable,
  input wire logic cmd_family,
  input wire logic [2:0] cmd_rate,
  input wire logic [3:0] cmd_src,
  input wire logic [15:0] cmd_core_word,
  input wire logic [4:0] cmd_sample_rate,
  // Readiness of the chosen source, from the user side
  input wire logic src_ready,
  input wire logic ao_rate_set,
  // Analogue path mute request and its acknowledge
  output logic mute_req,
  input wire logic mute_ack,
  // Result
  output logic done,
  output logic error,
  output logic [15:0] status_word,
  output logic audio_allowed,
  // Device register port
  output logic dev_sel,
  output logic dev_wr,
  output logic [15:0] dev_addr,
  output logic [15:0] dev_wdata,
  input wire logic [15:0] dev_rdata,
  input wire logic dev_ack
);
  import ascc_pkg::*;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_MUTE = 8'h02,
    ST_DIS = 8'h04,
    ST_RATE = 8'h08,
    ST_WORD = 8'h10,
    ST_MAIN = 8'h20,
    ST_STS = 8'h40,
    ST_END = 8'h80
  } ascc_st_e;

  ascc_st_e st_q;
  ascc_st_e st_d;
  ascc_dom_e dom_q;
  logic en_q;
  logic fam_q;
  logic [2:0] rate_q;
  logic [3:0] src_q;
  logic [15:0] word_q;
  logic [4:0] srate_q;
  logic [2:0] cur_rate_q [3];
  logic [3:0] cur_src_q [3];
  logic cur_en_q [3];
  logic cur_fam_q [3];
  logic done_q;
  logic err_q;
  logic [15:0] sts_q;
  logic main_up_q;
  logic second_ok_q;
  logic mute_q;
  logic req;
  logic req_wr;
  logic [15:0] req_addr;
  logic [15:0] req_wdata;
  logic req_done;
  logic [15:0] req_rdata;
  logic [4:0] wait_q;
  logic need_dis_q;
  logic need_mute_sticky;

  // Decode of the command against the domain's current settings
  wire logic [1:0] cmd_idx = cmd_domain;
  wire logic src_same = (cmd_src == cur_src_q[cmd_idx]);
  wire logic rate_same = (cmd_rate == cur_rate_q[cmd_idx]) &&
                         (cmd_family == cur_fam_q[cmd_idx]);
  wire logic running = cur_en_q[cmd_idx];
  wire logic is_loop = ascc_is_loop(cmd_src);
  wire logic is_ao = (cmd_src == SRC_AO) || (cmd_src == SRC_AO_X2);
  wire logic rate_bad = (cmd_domain != DOM_CORE) && (cmd_rate > RATE_MAX);
  wire logic fam_bad = (cmd_domain != DOM_CORE) &&
                       (ascc_is_frac(cmd_sample_rate) != cmd_family);
  wire logic src_bad = cmd_enable && !src_ready;
  wire logic ao_bad = is_ao && !ao_rate_set;
  wire logic loop_bad = is_loop && !src_ready;
  wire logic cmd_bad = rate_bad || fam_bad || src_bad || ao_bad || loop_bad;
  // Rate-only change while running needs the enable cleared first
  wire logic need_dis = running && src_same && !rate_same;
  // Changing main source moves the analogue paths: mute them first
  wire logic need_mute = (cmd_domain == DOM_MAIN) && running && !src_same;

  // Register word for the main and second domains, fields in one write
  wire logic cmd_domain_q_is_main = (dom_q == DOM_MAIN);
  wire logic [15:0] clk_word = ((cmd_domain_q_is_main ? 16'(fam_q) : 16'h0)
                                << FAMILY_POS) |
                               (16'(rate_q) << RATE_POS) |
                               (16'(en_q) << ENABLE_POS) |
                               (16'(src_q) << SRC_POS);
  // Core control word carries enable and source only
  wire logic [15:0] core_word = (16'(en_q) << ENABLE_POS) |
                                (16'(src_q) << SRC_POS);
  wire logic [15:0] dom_addr = (dom_q == DOM_MAIN) ? ADDR_MAIN_CLK :
                               (dom_q == DOM_SECOND) ? ADDR_SECOND_CLK :
                               ADDR_CORE_CLK;
  wire logic [15:0] sts_addr = (dom_q == DOM_MAIN) ? ADDR_MAIN_STS :
                               (dom_q == DOM_SECOND) ? ADDR_SECOND_STS :
                               ADDR_CORE_STS;
  wire logic [15:0] rate_addr = (dom_q == DOM_MAIN) ? ADDR_SRATE_1 :
                                ADDR_ASRATE_1;
  // Enable-cleared copy of what the device holds now: the new rate code
  // must not land before the enable is off
  wire logic [1:0] dom_idx = dom_q;
  wire logic [15:0] cur_word = ((cmd_domain_q_is_main ?
                                 16'(cur_fam_q[dom_idx]) : 16'h0)
                                << FAMILY_POS) |
                               (16'(cur_rate_q[dom_idx]) << RATE_POS) |
                               (16'(cur_src_q[dom_idx]) << SRC_POS);
  wire logic [15:0] dis_word = (dom_q == DOM_CORE) ?
                               (16'(cur_src_q[dom_idx]) << SRC_POS) :
                               cur_word;

  assign cmd_ready = (st_q == ST_IDLE);
  wire logic accept = cmd_valid && cmd_ready;

  // Next state of the sequencer
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (accept && !cmd_bad) begin
          st_d = need_mute ? ST_MUTE : (need_dis ? ST_DIS : ST_RATE);
        end
      end
      ST_MUTE: begin
        if (mute_ack) begin
          st_d = need_dis_q ? ST_DIS : ST_RATE;
        end
      end
      ST_DIS: begin
        if (req_done) begin
          st_d = ST_RATE;
        end
      end
      ST_RATE: begin
        if (req_done) begin
          st_d = (dom_q == DOM_CORE) ? ST_WORD : ST_MAIN;
        end
      end
      ST_WORD: begin
        if (req_done) begin
          st_d = ST_MAIN;
        end
      end
      ST_MAIN: begin
        if (req_done) begin
          st_d = ST_STS;
        end
      end
      ST_STS: begin
        if (req_done) begin
          st_d = ST_END;
        end
      end
      ST_END: st_d = ST_IDLE;
    endcase
  end

  // Bus request per state; core skips sample rate (ST_RATE writes word)
  assign req = (st_q == ST_DIS) || (st_q == ST_RATE) || (st_q == ST_WORD) ||
               (st_q == ST_MAIN) || (st_q == ST_STS);
  assign req_wr = (st_q != ST_STS);
  assign req_addr = (st_q == ST_DIS) ? dom_addr :
                    (st_q == ST_RATE && dom_q == DOM_CORE) ? ADDR_CORE_WORD :
                    (st_q == ST_RATE) ? rate_addr :
                    (st_q == ST_WORD) ? ADDR_CORE_WORD :
                    (st_q == ST_STS) ? sts_addr : dom_addr;
  assign req_wdata = (st_q == ST_DIS) ? dis_word :
                     (st_q == ST_RATE && dom_q != DOM_CORE) ? 16'(srate_q) :
                     (st_q == ST_RATE || st_q == ST_WORD) ? word_q :
                     (dom_q == DOM_CORE) ? core_word : clk_word;

  // Command capture and sequencer state
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      dom_q <= DOM_MAIN;
      en_q <= 1'b0;
      fam_q <= 1'b0;
      rate_q <= MAIN_RATE_RST;
      src_q <= MAIN_SRC_RST;
      word_q <= 16'h0000;
      srate_q <= SRATE_RST;
      need_dis_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (accept) begin
        dom_q <= cmd_domain;
        en_q <= cmd_enable;
        fam_q <= cmd_family;
        rate_q <= cmd_rate;
        src_q <= cmd_src;
        word_q <= cmd_core_word;
        srate_q <= cmd_sample_rate;
        need_dis_q <= need_dis;
      end
    end
  end

  // Shadow of what the device holds, per domain, tracked by our writes
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_shadow
      always_ff @(posedge clk_sys) begin
        if (!nrst) begin
          cur_en_q[gi] <= 1'b0;
          cur_fam_q[gi] <= 1'b0;
          cur_rate_q[gi] <= (gi == 1) ? SECOND_RATE_RST : MAIN_RATE_RST;
          cur_src_q[gi] <= (gi == 1) ? SECOND_SRC_RST : MAIN_SRC_RST;
        end else if (st_q == ST_MAIN && req_done && dom_q == 2'(gi)) begin
          cur_en_q[gi] <= en_q;
          cur_fam_q[gi] <= fam_q;
          cur_rate_q[gi] <= rate_q;
          cur_src_q[gi] <= src_q;
        end else if (st_q == ST_DIS && req_done && dom_q == 2'(gi)) begin
          cur_en_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Timeout on a stalled device access
  always_ff @(posedge clk_sys) begin
    if (!nrst || !req || req_done) begin
      wait_q <= 5'h00;
    end else if (wait_q != 5'h1f) begin
      wait_q <= wait_q + 5'h01;
    end
  end

  // Result flags; status readback shows the device's active settings
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      done_q <= 1'b0;
      err_q <= 1'b0;
      sts_q <= 16'h0000;
      mute_q <= 1'b0;
      main_up_q <= 1'b0;
      second_ok_q <= 1'b1;
    end else begin
      done_q <= (st_q == ST_END) || (accept && cmd_bad);
      if (accept) begin
        err_q <= cmd_bad;
      end else if (st_q == ST_STS && req_done) begin
        // Mismatch means the device has not applied the setting
        err_q <= (dom_q != DOM_CORE) &&
                 (req_rdata[RATE_POS +: 3] != rate_q ||
                  req_rdata[SRC_POS +: 4] != src_q);
      end
      if (st_q == ST_STS && req_done) begin
        sts_q <= req_rdata;
      end
      mute_q <= (st_d == ST_MUTE) || ((st_q != ST_IDLE) && mute_q &&
                                      (st_q != ST_END));
      if (st_q == ST_MAIN && req_done && dom_q == DOM_MAIN) begin
        main_up_q <= en_q;
      end
      if (st_q == ST_MAIN && req_done && dom_q == DOM_SECOND) begin
        second_ok_q <= 1'b1;
      end
    end
  end

  // Audio paths only once the main clock is running and idle
  assign audio_allowed = main_up_q && second_ok_q && (st_q == ST_IDLE);
  assign done = done_q;
  assign error = err_q;
  assign status_word = sts_q;
  assign mute_req = mute_q;

  // Device port master; the device applies itself
  ascc_bus u_bus (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .req(req),
    .req_wr(req_wr),
    .req_addr(req_addr),
    .req_wdata(req_wdata),
    .req_done(req_done),
    .req_rdata(req_rdata),
    .dev_sel(dev_sel),
    .dev_wr(dev_wr),
    .dev_addr(dev_addr),
    .dev_wdata(dev_wdata),
    .dev_rdata(dev_rdata),
    .dev_ack(dev_ack)
  );

  // Assertions
  AST_MUTE_BEFORE: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_q == ST_MAIN && dom_q == DOM_MAIN && req && need_mute_sticky)
    |-> mute_q) else $error("main source change without mute");
  AST_CORE_ORDER: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_q == ST_MAIN && dom_q == DOM_CORE) |-> $past(st_q) inside {ST_WORD,
    ST_MAIN}) else $error("core source written before word");
  AST_BAD_REFUSED: assert property (@(posedge clk_sys) disable iff (!nrst)
    (accept && cmd_bad) |=> (st_q == ST_IDLE) && err_q && done_q)
    else $error("illegal command not refused");
  AST_RATE_RANGE: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_q == ST_MAIN && dom_q != DOM_CORE) |-> rate_q <= RATE_MAX)
    else $error("rate code out of range");
  AST_DIS_FIRST: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_q == ST_DIS && req_done) |=> st_q == ST_RATE)
    else $error("disable not followed by rate write");
  AST_ONE_WRITE: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_q == ST_MAIN && dom_q != DOM_CORE) |-> req_wdata[RATE_POS +: 3] ==
    rate_q && req_wdata[SRC_POS +: 4] == src_q)
    else $error("fields not in one write");
  AST_AUDIO_GATE: assert property (@(posedge clk_sys) disable iff (!nrst)
    audio_allowed |-> main_up_q) else $error("audio before clock");
  AST_SRC_READY: assert property (@(posedge clk_sys) disable iff (!nrst)
    (accept && cmd_enable && !src_ready) |=> st_q == ST_IDLE)
    else $error("enable with source not ready");
  AST_NO_HANG: assert property (@(posedge clk_sys) disable iff (!nrst)
    wait_q != 5'h1f || st_q == ST_MUTE) else $error("device stalled");

  // Remembers that the accepted command needs the analogue paths muted
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      need_mute_sticky <= 1'b0;
    end else if (accept) begin
      need_mute_sticky <= need_mute && !cmd_bad;
    end
  end
endmodule : ascc_ctrl
`default_nettype wire

/* ascc_dev_model.sv */
// Behavioural model of the codec clock registers behind the controller
`timescale 1ns/1ps
`default_nettype none
module ascc_dev_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port
  input wire logic dev_sel,
  input wire logic dev_wr,
  input wire logic [15:0] dev_addr,
  input wire logic [15:0] dev_wdata,
  output logic [15:0] dev_rdata,
  output logic dev_ack,
  // Answer slowly while high
  input wire logic slow
);
  import ascc_pkg::*;
  logic [15:0] main_q, srate_q, second_q, asrate_q, core_q, word_q, act_q;
  logic [2:0] cnt_q;
  logic [15:0] wr_addr[$];
  logic [15:0] wr_data[$];
  // Status shows the settings in effect, never a pending word
  function automatic logic [15:0] rd(input logic [15:0] a);
    case (a)
      ADDR_MAIN_CLK: return main_q;
      ADDR_SECOND_CLK: return second_q;
      ADDR_MAIN_STS: return main_q & 16'h8707;
      ADDR_SECOND_STS: return second_q & 16'h0707;
      ADDR_CORE_STS: return act_q;
      default: return 16'h0000;
    endcase
  endfunction : rd
  // One access: a wait, then ack held until select drops
  always @(posedge clk_sys) begin
    if (!nrst) begin
      main_q <= {5'h00, MAIN_RATE_RST, 4'h0, MAIN_SRC_RST};
      second_q <= {5'h00, SECOND_RATE_RST, 4'h0, SECOND_SRC_RST};
      srate_q <= {11'h000, SRATE_RST};
      asrate_q <= {11'h000, SRATE_RST};
      core_q <= 16'h0000;
      word_q <= 16'h0000;
      act_q <= 16'h0000;
      dev_ack <= 1'b0;
      cnt_q <= 3'h0;
      dev_rdata <= 16'h5a5a;
    end else if (dev_sel && !dev_ack) begin
      if (cnt_q < (slow ? 3'h4 : 3'h1)) begin
        cnt_q <= cnt_q + 3'h1;
      end else begin
        cnt_q <= 3'h0;
        dev_ack <= 1'b1;
        if (dev_wr) begin
          wr_addr.push_back(dev_addr);
          wr_data.push_back(dev_wdata);
          // Whole control word lands at once, so the switch is seamless
          case (dev_addr)
            ADDR_MAIN_CLK: main_q <= dev_wdata;
            ADDR_SECOND_CLK: second_q <= dev_wdata;
            ADDR_SRATE_1: srate_q <= dev_wdata;
            ADDR_ASRATE_1: asrate_q <= dev_wdata;
            ADDR_CORE_WORD: word_q <= dev_wdata;
            ADDR_CORE_CLK: begin
              core_q <= dev_wdata;
              act_q <= word_q;
            end
            default: ;
          endcase
        end else begin
          dev_rdata <= rd(dev_addr);
        end
      end
    end else if (!dev_sel && dev_ack) begin
      dev_ack <= 1'b0;
      // A released bus must not keep showing the old value
      dev_rdata <= ~dev_rdata;
    end
  end
endmodule : ascc_dev_model
`default_nettype wire

/* ascc_pkg.sv */
// Package: register map, field layout and codes for the clock controller
package ascc_pkg;
  // Register indices of the device (word addresses)
  localparam logic [15:0] ADDR_MAIN_CLK = 16'h0101;
  localparam logic [15:0] ADDR_SRATE_1 = 16'h0102;
  localparam logic [15:0] ADDR_SECOND_CLK = 16'h0112;
  localparam logic [15:0] ADDR_ASRATE_1 = 16'h0113;
  localparam logic [15:0] ADDR_CORE_CLK = 16'h0120;
  localparam logic [15:0] ADDR_CORE_WORD = 16'h0122;
  localparam logic [15:0] ADDR_MAIN_STS = 16'h0106;
  localparam logic [15:0] ADDR_SECOND_STS = 16'h0116;
  localparam logic [15:0] ADDR_CORE_STS = 16'h0124;
  // Field positions
  localparam int FAMILY_POS = 15;
  localparam int RATE_POS = 8;
  localparam int ENABLE_POS = 6;
  localparam int SRC_POS = 0;
  // Reset values of the device fields
  localparam logic [2:0] MAIN_RATE_RST = 3'h4;
  localparam logic [3:0] MAIN_SRC_RST = 4'h4;
  localparam logic [2:0] SECOND_RATE_RST = 3'h3;
  localparam logic [3:0] SECOND_SRC_RST = 4'h5;
  localparam logic [4:0] SRATE_RST = 5'h11;
  // Highest legal rate code (98.304 MHz)
  localparam logic [2:0] RATE_MAX = 3'h4;
  // Sample rate family masks: 0x09..0x0d are the 44.1 kHz group
  localparam logic [4:0] SR_FRAC_LO = 5'h09;
  localparam logic [4:0] SR_FRAC_HI = 5'h0d;
  // Source codes
  localparam logic [3:0] SRC_LOOP_ONE = 4'h4;
  localparam logic [3:0] SRC_LOOP_TWO = 4'h5;
  localparam logic [3:0] SRC_AO_X2 = 4'h7;
  localparam logic [3:0] SRC_AO = 4'hf;
  // Cycles allowed between a write and its readback
  localparam int BUS_TIMEOUT = 16;
  // Domain selectors of a user command
  typedef enum logic [1:0] {
    DOM_MAIN = 2'h0,
    DOM_SECOND = 2'h1,
    DOM_CORE = 2'h2
  } ascc_dom_e;
  // True for a source that is one of the frequency-locked loops
  function automatic logic ascc_is_loop(input logic [3:0] s);
    return (s == SRC_LOOP_ONE) || (s == SRC_LOOP_TWO) ||
           (s == SRC_AO_X2) || (s == SRC_AO);
  endfunction : ascc_is_loop
  // True for a sample rate code of the 44.1 kHz family
  function automatic logic ascc_is_frac(input logic [4:0] r);
    return (r >= SR_FRAC_LO) && (r <= SR_FRAC_HI);
  endfunction : ascc_is_frac
endpackage : ascc_pkg

/* audio_system_clock_config_tb_top.sv */
// Self-checking testbench of the clock controller against the device model
`timescale 1ns/1ps
`default_nettype none
module audio_system_clock_config_tb_top;
  import ascc_pkg::*;
  logic clk_sys, nrst, cmd_valid, cmd_ready, cmd_enable, cmd_family;
  ascc_dom_e cmd_domain;
  logic [2:0] cmd_rate;
  logic [3:0] cmd_src;
  logic [15:0] cmd_core_word, status_word, dev_addr, dev_wdata, dev_rdata;
  logic [4:0] cmd_sample_rate;
  logic src_ready, ao_rate_set, mute_req, mute_ack, done, error;
  logic audio_allowed, dev_sel, dev_wr, dev_ack, slow, mute_seen;
  int errors, check_count, n0;

  ascc_ctrl i_ascc_ctrl (.clk_sys(clk_sys), .nrst(nrst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_domain(cmd_domain),
    .cmd_enable(cmd_enable), .cmd_family(cmd_family), .cmd_rate(cmd_rate),
    .cmd_src(cmd_src), .cmd_core_word(cmd_core_word),
    .cmd_sample_rate(cmd_sample_rate), .src_ready(src_ready),
    .ao_rate_set(ao_rate_set), .mute_req(mute_req), .mute_ack(mute_ack),
    .done(done), .error(error), .status_word(status_word),
    .audio_allowed(audio_allowed), .dev_sel(dev_sel), .dev_wr(dev_wr),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_rdata(dev_rdata),
    .dev_ack(dev_ack));
  ascc_dev_model i_ascc_dev_model (.clk_sys(clk_sys), .nrst(nrst),
    .dev_sel(dev_sel), .dev_wr(dev_wr), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_rdata(dev_rdata), .dev_ack(dev_ack),
    .slow(slow));

  // 25 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Mute is granted 2 ns after it is asked, in the same cycle, and remembered for the checks
  always @(posedge clk_sys) begin
    #2;
    mute_ack = mute_req;
    if (mute_req === 1'b1) mute_seen = 1'b1;
  end

  function automatic logic [15:0] mk(logic f, logic [2:0] r, logic e,
                                     logic [3:0] s);
    return {f, 4'h0, r, 1'b0, e, 2'b00, s};
  endfunction : mk
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask : chk1
  // One command; a refused one must not touch the device
  task automatic run_cmd(input ascc_dom_e d, input logic e, input logic f,
      input logic [2:0] r, input logic [3:0] s, input logic [15:0] w,
      input logic [4:0] sr, input logic exp_err);
    int k;
    n0 = i_ascc_dev_model.wr_addr.size();
    mute_seen = 1'b0;
    cmd_domain = d;
    cmd_enable = e;
    cmd_family = f;
    cmd_rate = r;
    cmd_src = s;
    cmd_core_word = w;
    cmd_sample_rate = sr;
    cmd_valid = 1'b1;
    // Ready is looked at off the edge, so the accepting edge is known
    while (cmd_ready !== 1'b1) begin
      @(posedge clk_sys);
      #2;
    end
    @(posedge clk_sys);
    #2 cmd_valid = 1'b0;
    for (k = 0; k < 400 && done !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    chk1(done, 1'b1);
    chk1(error, exp_err);
    if (exp_err) chk16(16'(i_ascc_dev_model.wr_addr.size()), 16'(n0));
    @(posedge clk_sys);
    #2;
  endtask : run_cmd
  task automatic give_verdict;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    give_verdict();
  end

  initial begin
    {nrst, cmd_valid, cmd_enable, cmd_family, cmd_rate, cmd_src} = '0;
    {cmd_core_word, cmd_sample_rate, slow} = '0;
    cmd_domain = DOM_MAIN;
    src_ready = 1'b1;
    ao_rate_set = 1'b1;
    mute_seen = 1'b0;
    errors = 0;
    check_count = 0;
    repeat (16) @(posedge clk_sys);
    #2 nrst = 1'b1;
    @(posedge clk_sys);
    #2;
    chk1(cmd_ready, 1'b1);
    chk1(audio_allowed, 1'b0);
    chk16(i_ascc_dev_model.main_q, 16'h0404);
    chk16(i_ascc_dev_model.second_q, 16'h0305);
    // Bring the main clock up from the reference input
    run_cmd(DOM_MAIN, 1, 0, 3'h3, 4'h0, 0, 5'h03, 0);
    chk16(i_ascc_dev_model.main_q, mk(0, 3'h3, 1, 4'h0));
    chk16(i_ascc_dev_model.srate_q, 16'h0003);
    chk16(status_word, mk(0, 3'h3, 1, 4'h0) & 16'h8707);
    chk1(audio_allowed, 1'b1);
    // Rate only while running: a disabling write comes first
    run_cmd(DOM_MAIN, 1, 0, 3'h4, 4'h0, 0, 5'h03, 0);
    chk16(i_ascc_dev_model.wr_addr[n0], ADDR_MAIN_CLK);
    chk16(i_ascc_dev_model.wr_data[n0], mk(0, 3'h3, 0, 4'h0));
    chk1(mute_seen, 1'b0);
    chk16(i_ascc_dev_model.main_q, mk(0, 3'h4, 1, 4'h0));
    // Source change while running: mute, then one combined write
    n0 = i_ascc_dev_model.wr_addr.size();
    run_cmd(DOM_MAIN, 1, 1, 3'h4, SRC_LOOP_ONE, 0, 5'h0b, 0);
    chk1(mute_seen, 1'b1);
    chk16(i_ascc_dev_model.main_q, mk(1, 3'h4, 1, SRC_LOOP_ONE));
    chk16(status_word, mk(1, 3'h4, 0, SRC_LOOP_ONE));
    // Refused commands leave the device alone; the last one, an always-on loop with its rate set, is taken
    run_cmd(DOM_MAIN, 1, 1, 3'h5, SRC_LOOP_ONE, 0, 5'h0b, 1);
    run_cmd(DOM_MAIN, 1, 0, 3'h4, SRC_LOOP_ONE, 0, 5'h0b, 1);
    src_ready = 1'b0;
    run_cmd(DOM_MAIN, 1, 1, 3'h4, SRC_LOOP_TWO, 0, 5'h0b, 1);
    src_ready = 1'b1;
    ao_rate_set = 1'b0;
    run_cmd(DOM_MAIN, 1, 1, 3'h3, SRC_AO, 0, 5'h0b, 1);
    ao_rate_set = 1'b1;
    run_cmd(DOM_MAIN, 1, 1, 3'h4, SRC_AO_X2, 0, 5'h0b, 0);
    chk16(i_ascc_dev_model.main_q, mk(1, 3'h4, 1, SRC_AO_X2));
    // Second clock through a slow device, 44.1 kHz group
    slow = 1'b1;
    run_cmd(DOM_SECOND, 1, 1, 3'h3, SRC_LOOP_TWO, 0, 5'h0d, 0);
    chk16(i_ascc_dev_model.second_q, mk(0, 3'h3, 1, SRC_LOOP_TWO));
    chk16(i_ascc_dev_model.asrate_q, 16'h000d);
    chk16(status_word, mk(0, 3'h3, 0, SRC_LOOP_TWO));
    slow = 1'b0;
    // Core clock: 96 MHz word lands before the source write applies it
    run_cmd(DOM_CORE, 1, 0, 3'h0, SRC_LOOP_ONE, 16'h1800, 5'h00, 0);
    chk16(i_ascc_dev_model.wr_addr[$], ADDR_CORE_CLK);
    chk16(i_ascc_dev_model.wr_data[$] & 16'h000f, 16'h0004);
    chk16(i_ascc_dev_model.act_q, 16'h1800);
    chk16(status_word, 16'h1800);
    give_verdict();
  end
endmodule : audio_system_clock_config_tb_top
`default_nettype wire
